//--- rtl/mii_rmii_phy_port.sv
// mii and rmii port logic towards external phys, with tx shift compensation
`timescale 1ns/1ps
`default_nettype none
// How it works
// - low link pin means 100M full-duplex link
// - mii rx nibble, valid, error on rx clock
// - rmii rx and tx timed by 50M reference
// - rmii mode serves two ports at most
// - mii tx launched from 25M core tick
// - tx enable and data change together
// - manual shift delays tx by 10ns steps
// - feedback clock plus zero shift: auto shift
// - aim tx changes mid 0..25ns window
// - link may come from management instead
// - any phy address offset accepted
// - phy address is port plus base
module mii_rmii_phy_port
  import phy_port_pkg::*;
#(
  parameter int PN = 3
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // configuration
  input wire logic rmii_mode,
  input wire logic link_via_mgmt,
  input wire logic [PN-1:0] mgmt_link_up,
  input wire logic [4:0] phy_address_base,
  // mii pins
  input wire logic [PN-1:0] mii_link_up_n,
  input wire logic [PN-1:0] mii_rx_clk,
  input wire logic [PN-1:0] nibble_rx_valid,
  input wire logic [PN-1:0] mii_rx_err,
  input wire logic [PN-1:0][3:0] mii_rx_data,
  input wire logic [PN-1:0] mii_tx_clk,
  input wire logic [PN-1:0][1:0] mii_tx_shift,
  output logic [PN-1:0] nibble_tx_enable,
  output logic [PN-1:0][3:0] nibble_tx_data,
  // rmii pins
  input wire logic reduced_ref_clock_50m,
  input wire logic [RMII_MAX_PORTS-1:0] rmii_link_up_n,
  input wire logic [RMII_MAX_PORTS-1:0] dibit_rx_valid,
  input wire logic [RMII_MAX_PORTS-1:0] rmii_rx_err,
  input wire logic [RMII_MAX_PORTS-1:0][1:0] rmii_rx_data,
  output logic [RMII_MAX_PORTS-1:0] dibit_tx_enable,
  output logic [RMII_MAX_PORTS-1:0][1:0] rmii_tx_data,
  // user transmit side
  input wire logic [PN-1:0][7:0] tx_data,
  input wire logic [PN-1:0] tx_valid,
  output logic [PN-1:0] tx_take,
  // user receive side and status
  output rx_word_s [PN-1:0] rx_word,
  output logic [PN-1:0] rx_strobe,
  output logic [PN-1:0] rx_active,
  output logic [PN-1:0] link_up,
  output logic [PN-1:0][4:0] phy_address
);
  localparam int MW = PN * 11;
  localparam int RW = 1 + RMII_MAX_PORTS * 5;

  typedef struct packed {
    logic [2:0] div;
    logic [PN-1:0] rxc_d;
    logic [PN-1:0] txc_d;
    logic ref_d;
    logic [PN-1:0][7:0] rx_sh;
    logic [PN-1:0][1:0] rx_cnt;
    logic [PN-1:0] rx_acc;
    rx_word_s [PN-1:0] word;
    logic [PN-1:0] stb;
    logic [PN-1:0] act;
    logic [PN-1:0][7:0] tx_sh;
    logic [PN-1:0][1:0] tx_cnt;
    logic [PN-1:0] busy;
    logic [PN-1:0] take;
    tx_pins_s [PN-1:0] stage;
    tx_pins_s [PN-1:0][PIPE_DEPTH-1:0] pipe;
    tx_pins_s [PN-1:0] mout;
    tx_pins_s [RMII_MAX_PORTS-1:0] dout;
    logic [PN-1:0] fb_seen;
    logic [PN-1:0][1:0] auto_sh;
    logic [PN-1:0] link;
    logic [PN-1:0][4:0] addr;
    logic [1:0] warm;
  } state_s;

  state_s r;
  state_s n;
  logic [MW-1:0] mq;
  logic [RW-1:0] rq;
  logic [PN-1:0] ml_q, mc_q, mv_q, me_q, mt_q;
  logic [PN-1:0][3:0] md_q;
  logic [PN-1:0][1:0] ms_q;
  logic rc_q;
  logic [RMII_MAX_PORTS-1:0] rl_q, rv_q, re_q;
  logic [RMII_MAX_PORTS-1:0][1:0] rd_q;
  logic [PN-1:0][1:0] eff;

  // every phy pin, including link and shift straps, is resynchronised
  bit_sync #(.W(MW)) u_mii_sync (
    .mclk(mclk),
    .reset(reset),
    .d({mii_link_up_n, mii_rx_clk, nibble_rx_valid, mii_rx_err,
        mii_tx_clk, mii_rx_data, mii_tx_shift}),
    .q(mq)
  );

  bit_sync #(.W(RW)) u_rmii_sync (
    .mclk(mclk),
    .reset(reset),
    .d({rmii_link_up_n, reduced_ref_clock_50m, dibit_rx_valid, rmii_rx_err,
        rmii_rx_data}),
    .q(rq)
  );

  assign {ml_q, mc_q, mv_q, me_q, mt_q, md_q, ms_q} = mq;
  assign {rl_q, rc_q, rv_q, re_q, rd_q} = rq;

  // auto shift when manual is zero
  always_comb begin
    for (int p = 0; p < PN; p++) begin
      if (ms_q[p] == 2'h0 && r.fb_seen[p]) begin
        eff[p] = r.auto_sh[p];
      end else begin
        eff[p] = ms_q[p];
      end
    end
  end

  always_comb begin
    logic tick, ref_rise, ok, ev, dv, er, acc, lev;
    logic [1:0] last;
    logic [7:0] sh_in;
    logic [2:0] d;
    int q;
    tx_pins_s tap;
    tick = 1'b0;
    ref_rise = 1'b0;
    ok = 1'b0;
    ev = 1'b0;
    dv = 1'b0;
    er = 1'b0;
    acc = 1'b0;
    lev = 1'b0;
    last = 2'h0;
    sh_in = 8'h00;
    d = 3'h0;
    q = 0;
    tap = '0;
    n = r;
    tick = (r.div == DIV_LAST);
    n.div = tick ? 3'h0 : r.div + 3'h1;
    ref_rise = rc_q & ~r.ref_d;
    n.ref_d = rc_q;
    n.rxc_d = mc_q;
    n.txc_d = mt_q;
    n.stb = '0;
    n.take = '0;
    // sync resets low, so link pins read as up until both stages fill
    n.warm = {r.warm[0], 1'b1};
    for (int p = 0; p < PN; p++) begin
      q = p % RMII_MAX_PORTS;
      // ports beyond two idle in rmii
      ok = !rmii_mode || (p < RMII_MAX_PORTS);
      if (!ok) begin
        n.link[p] = 1'b0;
      end else if (link_via_mgmt) begin
        n.link[p] = mgmt_link_up[p];
      end else if (rmii_mode) begin
        n.link[p] = !rl_q[q] && r.warm[1];
      end else begin
        n.link[p] = !ml_q[p] && r.warm[1];
      end
      n.addr[p] = phy_address_base + 5'(p);
      ev = rmii_mode ? ref_rise : (mc_q[p] & ~r.rxc_d[p]);
      dv = rmii_mode ? rv_q[q] : mv_q[p];
      er = rmii_mode ? re_q[q] : me_q[p];
      last = rmii_mode ? DIB_LAST : NIB_LAST;
      // later units fill from the top
      sh_in = rmii_mode ? {rd_q[q], r.rx_sh[p][7:2]}
                        : {md_q[p], r.rx_sh[p][7:4]};
      acc = r.rx_acc[p] | er;
      if (!ok) begin
        n.act[p] = 1'b0;
        n.rx_cnt[p] = 2'h0;
        n.rx_acc[p] = 1'b0;
      end else if (ev && dv) begin
        n.act[p] = 1'b1;
        n.rx_sh[p] = sh_in;
        if (r.rx_cnt[p] == last) begin
          n.word[p].err = acc;
          n.word[p].data = sh_in;
          n.stb[p] = 1'b1;
          n.rx_cnt[p] = 2'h0;
          n.rx_acc[p] = 1'b0;
        end else begin
          n.rx_cnt[p] = r.rx_cnt[p] + 2'h1;
          n.rx_acc[p] = acc;
        end
      end else if (ev) begin
        // a partial byte at frame end is dropped
        n.act[p] = 1'b0;
        n.rx_cnt[p] = 2'h0;
        n.rx_acc[p] = 1'b0;
      end
      lev = rmii_mode ? ref_rise : tick;
      if (!ok) begin
        n.busy[p] = 1'b0;
        n.stage[p] = '0;
      end else if (lev) begin
        // low unit of each byte first
        if (r.busy[p] && r.tx_cnt[p] != 2'h0) begin
          n.stage[p].en = 1'b1;
          n.stage[p].data = rmii_mode ? {2'h0, r.tx_sh[p][1:0]}
                                      : r.tx_sh[p][3:0];
          n.tx_sh[p] = rmii_mode ? {2'h0, r.tx_sh[p][7:2]}
                                 : {4'h0, r.tx_sh[p][7:4]};
          n.tx_cnt[p] = r.tx_cnt[p] - 2'h1;
        end else if (tx_valid[p]) begin
          n.busy[p] = 1'b1;
          n.take[p] = 1'b1;
          n.stage[p].en = 1'b1;
          n.stage[p].data = rmii_mode ? {2'h0, tx_data[p][1:0]}
                                      : tx_data[p][3:0];
          n.tx_sh[p] = rmii_mode ? {2'h0, tx_data[p][7:2]}
                                 : {4'h0, tx_data[p][7:4]};
          n.tx_cnt[p] = last;
        end else begin
          n.busy[p] = 1'b0;
          n.stage[p] = '0;
        end
      end
      n.pipe[p][0] = r.stage[p];
      for (int k = 1; k < PIPE_DEPTH; k++) begin
        n.pipe[p][k] = r.pipe[p][k-1];
      end
      // phase of feedback clock picks shift
      if (mt_q[p] & ~r.txc_d[p]) begin
        n.fb_seen[p] = 1'b1;
        d = r.div + AUTO_BIAS;
        n.auto_sh[p] = (d >= AUTO_CLIP) ? 2'h3 : 2'((d + 3'h1) >> 1);
      end
      // one tap feeds enable and data
      if (eff[p] == 2'h0) begin
        tap = r.stage[p];
      end else begin
        tap = r.pipe[p][SHIFT_STEP_CYC * int'(eff[p]) - 1];
      end
      n.mout[p] = rmii_mode ? tx_pins_s'('0) : tap;
    end
    // rmii launches unshifted on the reference
    for (int p = 0; p < RMII_MAX_PORTS; p++) begin
      n.dout[p] = rmii_mode ? r.stage[p] : tx_pins_s'('0);
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  always_comb begin
    for (int p = 0; p < PN; p++) begin
      nibble_tx_enable[p] = r.mout[p].en;
      nibble_tx_data[p] = r.mout[p].data;
    end
    for (int p = 0; p < RMII_MAX_PORTS; p++) begin
      dibit_tx_enable[p] = r.dout[p].en;
      rmii_tx_data[p] = r.dout[p].data[1:0];
    end
  end

  assign tx_take = r.take;
  assign rx_word = r.word;
  assign rx_strobe = r.stb;
  assign rx_active = r.act;
  assign link_up = r.link;
  assign phy_address = r.addr;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  property p_pin_link;
    !link_via_mgmt && !rmii_mode && r.warm[1] |=>
      link_up[0] == !$past(ml_q[0]);
  endproperty
  a_pin_link: assert property (p_pin_link)
    else $error("link does not follow link pin");

  property p_mgmt_link;
    link_via_mgmt && !rmii_mode |=> link_up[0] == $past(mgmt_link_up[0]);
  endproperty
  a_mgmt_link: assert property (p_mgmt_link)
    else $error("link does not follow management status");

  property p_rmii_ports;
    (PN > RMII_MAX_PORTS) && rmii_mode |=>
      !link_up[PN-1] && !rx_active[PN-1] && !tx_take[PN-1];
  endproperty
  a_rmii_ports: assert property (p_rmii_ports)
    else $error("third port active in rmii mode");

  property p_phy_addr;
    1'b1 |=> phy_address[PN-1] == $past(phy_address_base) + 5'(PN - 1);
  endproperty
  a_phy_addr: assert property (p_phy_addr)
    else $error("phy address not base plus port");

  property p_launch_tick;
    !rmii_mode && $past(!rmii_mode) && $changed(r.stage[0]) |->
      r.div == 3'h0;
  endproperty
  a_launch_tick: assert property (p_launch_tick)
    else $error("tx launched off the core tick");

  property p_idle_data;
    !nibble_tx_enable[0] |-> nibble_tx_data[0] == 4'h0;
  endproperty
  a_idle_data: assert property (p_idle_data)
    else $error("tx data moves without enable");

  sequence s_shift_two;
    (!rmii_mode && eff[0] == 2'h2) [*6];
  endsequence
  property p_shift_two;
    s_shift_two |=> nibble_tx_enable[0] == $past(r.stage[0].en, 5) &&
      nibble_tx_data[0] == $past(r.stage[0].data, 5);
  endproperty
  a_shift_two: assert property (p_shift_two)
    else $error("shift of 20ns not applied");

  property p_shift_zero;
    (!rmii_mode && eff[0] == 2'h0) [*2] |=>
      nibble_tx_enable[0] == $past(r.stage[0].en, 1);
  endproperty
  a_shift_zero: assert property (p_shift_zero)
    else $error("zero shift adds delay");

  sequence s_fb_mid;
    mt_q[1] && !r.txc_d[1] &&
      (3'(r.div + AUTO_BIAS) inside {3'h3, 3'h4});
  endsequence
  property p_auto_shift;
    s_fb_mid ##1 ms_q[1] == 2'h0 |-> eff[1] == 2'h2;
  endproperty
  a_auto_shift: assert property (p_auto_shift)
    else $error("auto shift setting wrong");

  sequence s_mii_last;
    !rmii_mode && mc_q[0] && !r.rxc_d[0] && mv_q[0] &&
      r.rx_cnt[0] == NIB_LAST;
  endsequence
  property p_mii_byte;
    s_mii_last |=> rx_strobe[0] &&
      rx_word[0].data == {$past(md_q[0]), $past(r.rx_sh[0][7:4])};
  endproperty
  a_mii_byte: assert property (p_mii_byte)
    else $error("mii byte not assembled lsb first");

  sequence s_rmii_last;
    rmii_mode && rc_q && !r.ref_d && rv_q[0] && r.rx_cnt[0] == DIB_LAST;
  endsequence
  property p_rmii_byte;
    s_rmii_last |=> rx_strobe[0] &&
      rx_word[0].data == {$past(rd_q[0]), $past(r.rx_sh[0][7:2])};
  endproperty
  a_rmii_byte: assert property (p_rmii_byte)
    else $error("rmii byte not assembled lsb first");
endmodule
`default_nettype wire

//--- rtl/phy_port_pkg.sv
// constants and carrier types for the mii/rmii phy port block
package phy_port_pkg;
  localparam int MCLK_MHZ = 200;
  localparam int MCLK_PERIOD_NS = 5;
  localparam int CORE_CLOCK_MHZ = 25;
  localparam int CORE_DIV = MCLK_MHZ / CORE_CLOCK_MHZ;
  localparam logic [2:0] DIV_LAST = 3'(CORE_DIV - 1);
  localparam int TX_SHIFT_STEP_NS = 10;
  localparam int SHIFT_STEP_CYC =
    (TX_SHIFT_STEP_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam int SHIFT_MAX = 3;
  localparam int PIPE_DEPTH = SHIFT_MAX * SHIFT_STEP_CYC;
  localparam int TX_WINDOW_NS = 25;
  localparam int CENTER_CYC = TX_WINDOW_NS / 2 / MCLK_PERIOD_NS;
  localparam int SYNC_LAT = 2;
  localparam logic [2:0] AUTO_BIAS = 3'(CENTER_CYC - SYNC_LAT + CORE_DIV);
  localparam logic [2:0] AUTO_CLIP = 3'h6;
  localparam int RMII_MAX_PORTS = 2;
  localparam logic [1:0] NIB_LAST = 2'h1;
  localparam logic [1:0] DIB_LAST = 2'h3;

  typedef struct packed {
    logic en;
    logic [3:0] data;
  } tx_pins_s;

  typedef struct packed {
    logic err;
    logic [7:0] data;
  } rx_word_s;
endpackage

//--- rtl/bit_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module bit_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_s;

  sync_s r;
  sync_s n;

  always_comb begin
    n.s1 = d;
    n.s2 = r.s1;
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign q = r.s2;
endmodule
`default_nettype wire

//--- tb/phy_model.sv
// behavioural phy: mii and rmii receive side facing the port block
`timescale 1ns/1ps
`default_nettype none
module phy_model (
  // mii receive pins
  output logic rx_clk,
  output logic rx_dv,
  output logic rx_err,
  output logic [3:0] rx_d,
  // rmii receive pins
  output logic ref_clk,
  output logic rdv,
  output logic rerr,
  output logic [1:0] rd
);
  initial begin
    rx_clk = 1'b0;
    rx_dv = 1'b0;
    rx_err = 1'b0;
    rx_d = 4'h0;
    ref_clk = 1'b0;
    rdv = 1'b0;
    rerr = 1'b0;
    rd = 2'h0;
  end
  always #24 ref_clk = ~ref_clk;
  // low nibble first
  // rx clock pulses once more after the frame with valid low, released data shows inverse
  task automatic mii_frame(input logic [7:0] b, input logic e);
    for (int i = 0; i < 3; i++) begin
      rx_dv = (i < 2);
      rx_err = e && (i < 2);
      rx_d = (i < 2) ? b[4*i +: 4] : ~rx_d;
      #24 rx_clk = 1'b1;
      #24 rx_clk = 1'b0;
    end
  endtask
  // bits 1:0 first, change on falling reference edge
  task automatic rmii_frame(input logic [7:0] b);
    for (int i = 0; i < 5; i++) begin
      @(negedge ref_clk);
      rdv = (i < 4);
      rd = (i < 4) ? b[2*i +: 2] : ~rd;
    end
    @(negedge ref_clk);
  endtask
endmodule
`default_nettype wire

//--- tb/mii_rmii_phy_port_tb.sv
// self-checking bench for the mii/rmii phy port block
`timescale 1ns/1ps
`default_nettype none
module mii_rmii_phy_port_tb;
  import phy_port_pkg::*;
  localparam int PN = 3;
  int errors = 0;
  int comparisons = 0;
  int cycles = 0;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic rmii_mode = 1'b0;
  logic link_via_mgmt = 1'b0;
  logic fb_on = 1'b0;
  logic [PN-1:0] mgmt_link_up = '0;
  logic [4:0] phy_address_base = 5'h00;
  logic [PN-1:0] mii_link_up_n = '1;
  logic [RMII_MAX_PORTS-1:0] rmii_link_up_n = '1;
  // feedback held low on manual ports
  logic [PN-1:0] tx_fb = '0;
  logic [PN-1:0][1:0] shift = '0;
  logic [PN-1:0][7:0] tx_data = '0;
  logic [PN-1:0] tx_valid = '0;
  logic [PN-1:0] tx_take, rx_strobe, link_up, nibble_tx_enable, rx_active;
  realtime fb_rise = 0.0;
  logic [PN-1:0][3:0] nibble_tx_data;
  logic [PN-1:0][4:0] phy_address;
  logic [1:0] dibit_tx_enable;
  logic [1:0][1:0] rmii_tx_data;
  rx_word_s [PN-1:0] rx_word;
  logic rx_clk, rx_dv, rx_err, ref_clk, rdv, rerr;
  logic [3:0] rx_d;
  logic [1:0] rd;

  always #2.5 mclk = ~mclk;
  // feedback locked to the 25 MHz core rate
  // phase is fixed here, so no outside fifo is needed
  always #20 tx_fb[1] = fb_on && ($time % 40 == 0);
  always @(posedge tx_fb[1]) fb_rise = $realtime;

  phy_model i_phy (.rx_clk(rx_clk), .rx_dv(rx_dv), .rx_err(rx_err),
    .rx_d(rx_d), .ref_clk(ref_clk), .rdv(rdv), .rerr(rerr), .rd(rd));

  mii_rmii_phy_port #(.PN(PN)) i_dut (.mclk(mclk), .reset(reset),
    .rmii_mode(rmii_mode), .link_via_mgmt(link_via_mgmt),
    .mgmt_link_up(mgmt_link_up), .phy_address_base(phy_address_base),
    .mii_link_up_n(mii_link_up_n), .mii_rx_clk({2'h0, rx_clk}),
    .nibble_rx_valid({2'h0, rx_dv}), .mii_rx_err({2'h0, rx_err}),
    .mii_rx_data({8'h00, rx_d}), .mii_tx_clk(tx_fb), .mii_tx_shift(shift),
    .nibble_tx_enable(nibble_tx_enable), .nibble_tx_data(nibble_tx_data),
    .reduced_ref_clock_50m(ref_clk), .rmii_link_up_n(rmii_link_up_n),
    .dibit_rx_valid({1'b0, rdv}), .rmii_rx_err({1'b0, rerr}),
    .rmii_rx_data({2'h0, rd}), .dibit_tx_enable(dibit_tx_enable),
    .rmii_tx_data(rmii_tx_data), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_take(tx_take), .rx_word(rx_word), .rx_strobe(rx_strobe),
    .rx_active(rx_active), .link_up(link_up), .phy_address(phy_address));

  task automatic report_and_stop();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 30000) begin
      errors++;
      report_and_stop();
    end
  end

  task automatic chk(input string name, input logic [8:0] exp,
                     input logic [8:0] got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic step();
    @(posedge mclk);
    #1;
  endtask

  task automatic wait_take(input int p);
    int n = 0;
    while (tx_take[p] !== 1'b1 && n < 20) begin
      step();
      n++;
    end
    tx_valid[p] = 1'b0;
    chk("tx_take", 9'h001, 9'(tx_take[p]));
  endtask

  task automatic wait_strobe(input int p);
    int n = 0;
    while (rx_strobe[p] !== 1'b1 && n < 200) begin
      step();
      n++;
    end
    chk("rx_strobe", 9'h001, 9'(rx_strobe[p]));
  endtask

  task automatic t_link();
    mii_link_up_n = 3'b110;
    repeat (4) step();
    chk("link_up", 9'h001, 9'(link_up));
    link_via_mgmt = 1'b1;
    mgmt_link_up = 3'b110;
    repeat (2) step();
    chk("mgmt link_up", 9'h006, 9'(link_up));
    link_via_mgmt = 1'b0;
  endtask

  task automatic t_addr();
    for (int k = 0; k < 2; k++) begin
      phy_address_base = k ? 5'h1F : 5'h04;
      repeat (2) step();
      for (int p = 0; p < PN; p++) begin
        chk("phy_address", 9'(5'(phy_address_base + p)),
            9'(phy_address[p]));
      end
    end
  endtask

  // manual shift s: lag 1+2s cycles, launches 8 cycles apart
  task automatic t_mii_tx();
    int n;
    for (int s = 0; s < 4; s++) begin
      shift[0] = 2'(s);
      repeat (3) step();
      tx_data[0] = 8'hA5;
      tx_valid[0] = 1'b1;
      wait_take(0);
      n = 0;
      while (nibble_tx_enable[0] !== 1'b1 && n < 12) begin
        step();
        n++;
      end
      chk("tx lag", 9'(1 + 2 * s), 9'(n));
      chk("tx low", 9'h005, 9'(nibble_tx_data[0]));
      repeat (8) step();
      chk("tx high", 9'h01A,
          9'({nibble_tx_enable[0], nibble_tx_data[0]}));
      repeat (8) step();
      chk("tx end", 9'h000, 9'(nibble_tx_enable[0]));
    end
  endtask

  task automatic t_mii_rx(input logic [7:0] b, input logic e);
    fork
      i_phy.mii_frame(b, e);
      begin
        wait_strobe(0);
        chk("rx_active", 9'h001, 9'(rx_active[0]));
      end
    join
    chk("rx_word", {e, b}, 9'(rx_word[0]));
    chk("rx_active end", 9'h000, 9'(rx_active[0]));
  endtask

  // port 1 sends dibits, port 2 is not served in this mode
  task automatic t_rmii();
    logic [2:0] prev;
    int n;
    rmii_mode = 1'b1;
    rmii_link_up_n = 2'b10;
    mii_link_up_n = 3'b000;
    fork
      i_phy.rmii_frame(8'h96);
      wait_strobe(0);
    join
    chk("rmii rx_word", 9'h096, 9'(rx_word[0]));
    chk("rmii link_up", 9'h001, 9'(link_up));
    tx_data[1] = 8'h1B;
    tx_valid = 3'b110;
    wait_take(1);
    n = 0;
    while (dibit_tx_enable[1] !== 1'b1 && n < 12) begin
      step();
      n++;
    end
    for (int i = 0; i < 4; i++) begin
      chk("dibit", 9'(3 - i), 9'(rmii_tx_data[1]));
      prev = {dibit_tx_enable[1], rmii_tx_data[1]};
      n = 0;
      while ({dibit_tx_enable[1], rmii_tx_data[1]} === prev && n < 20) begin
        step();
        n++;
      end
    end
    chk("rmii end", 9'h000, 9'(dibit_tx_enable[1]));
    chk("mii tx off", 9'h000, 9'(nibble_tx_enable));
    tx_valid = '0;
    rmii_mode = 1'b0;
  endtask

  // zero manual shift with feedback running picks a shift itself
  task automatic t_auto();
    int n = 0;
    realtime dt;
    fb_on = 1'b1;
    repeat (40) step();
    tx_data[1] = 8'h5A;
    tx_valid[1] = 1'b1;
    wait_take(1);
    while (nibble_tx_enable[1] !== 1'b1 && n < 12) begin
      step();
      n++;
    end
    chk("auto lag odd", 9'h001, 9'(n % 2));
    chk("auto lag max", 9'h001, 9'(n <= 7));
    // enable rose at the edge just before this sample
    dt = $realtime - 1.0 - fb_rise;
    chk("auto phase", 9'h001, 9'(dt > 5.0 && dt < 20.0));
  endtask

  initial begin
    repeat (6) @(posedge mclk);
    #1 reset = 1'b0;
    step();
    t_link();
    t_addr();
    t_mii_tx();
    t_mii_rx(8'h3C, 1'b0);
    t_mii_rx(8'hC5, 1'b1);
    t_rmii();
    t_auto();
    report_and_stop();
  end
endmodule
`default_nettype wire
